// [core/lgr_pkg.sv]
// Purpose: shared constants and types of the LED group brightness block
// Assumes: 40 MHz system clock
// Notes: brightness levels are in thousandths of a percent of full scale
package lgr_pkg;

  localparam logic [6:0] DEV_ADDR = 7'h36;

  // Register offsets
  localparam logic [7:0] OFS_GP = 8'h10;
  localparam logic [7:0] OFS_RAMP = 8'h20;
  localparam logic [7:0] OFS_VF = 8'h60;
  localparam logic [7:0] OFS_MAIN = 8'hA0;
  localparam logic [7:0] OFS_AUX = 8'hB0;
  localparam logic [7:0] OFS_IND = 8'hC0;

  // Fixed read-back bits, power-on values and field widths
  localparam logic [7:0] GP_FIXED = 8'h00;
  localparam logic [7:0] RAMP_FIXED = 8'hF0;
  localparam logic [7:0] VF_FIXED = 8'hFC;
  localparam logic [7:0] MAIN_FIXED = 8'hE0;
  localparam logic [7:0] AUX_FIXED = 8'hF8;
  localparam logic [7:0] IND_FIXED = 8'hF8;
  localparam logic [7:0] GP_RST = 8'h00;
  localparam logic [7:0] RAMP_RST = 8'hF0;
  localparam logic [7:0] VF_RST = 8'hFC;
  localparam logic [7:0] MAIN_RST = 8'hE0;
  localparam logic [7:0] AUX_RST = 8'hF8;
  localparam logic [7:0] IND_RST = 8'hF8;
  localparam int GP_W = 7;
  localparam int MAIN_W = 5;
  localparam int BC_W = 3;

  // Timing: base tick of the ramp and the four dwell times
  localparam int CLK_MHZ = 40;
  localparam int RAMP_TICK_US = 100;
  localparam int RAMP_TICK_CYC = RAMP_TICK_US * CLK_MHZ;
  localparam int STEP0_US = 100;
  localparam int STEP1_US = 25000;
  localparam int STEP2_US = 50000;
  localparam int STEP3_US = 100000;
  localparam logic [9:0] STEP0_TK = 10'(STEP0_US / RAMP_TICK_US);
  localparam logic [9:0] STEP1_TK = 10'(STEP1_US / RAMP_TICK_US);
  localparam logic [9:0] STEP2_TK = 10'(STEP2_US / RAMP_TICK_US);
  localparam logic [9:0] STEP3_TK = 10'(STEP3_US / RAMP_TICK_US);

  // Gain transition delays, least figure of each range in microseconds
  localparam int VF0_US = 3000;
  localparam int VF1_US = 1500;
  localparam int VF2_US = 400;
  localparam int VF3_US = 60;
  localparam int VF0_CYC = VF0_US * CLK_MHZ;
  localparam int VF1_CYC = VF1_US * CLK_MHZ;
  localparam int VF2_CYC = VF2_US * CLK_MHZ;
  localparam int VF3_CYC = VF3_US * CLK_MHZ;

  // Level tables, index 0 at the right
  localparam logic [31:0][16:0] MAIN_TBL = {
    17'd100000, 17'd87500, 17'd70000, 17'd61250, 17'd52500, 17'd43750,
    17'd37500, 17'd31250, 17'd26250, 17'd22500, 17'd18750, 17'd16875,
    17'd15000, 17'd12500, 17'd10000, 17'd8750, 17'd7500, 17'd6250,
    17'd5250, 17'd4375, 17'd3750, 17'd3125, 17'd2813, 17'd2438,
    17'd2063, 17'd1688, 17'd1313, 17'd1125, 17'd1000, 17'd625,
    17'd313, 17'd125};
  localparam logic [7:0][16:0] BC_TBL = {
    17'd100000, 17'd70000, 17'd60000, 17'd50000, 17'd40000, 17'd30000,
    17'd20000, 17'd10000};

  typedef struct packed {
    logic second_off;
    logic first_off;
    logic second_to_main;
    logic first_to_main;
    logic ind_en;
    logic aux_en;
    logic main_en;
  } lgr_gp_s;

  typedef struct packed {
    logic on;
    logic [16:0] level;
  } lgr_sink_s;

  typedef struct packed {
    logic stb;
    logic [7:0] addr;
    logic [7:0] data;
  } lgr_wr_s;

endpackage

// [core/lgr_i2c.sv]
// Purpose: write/read target of the two-wire control bus
// Assumes: SCL and SDA are pins, synchronised here
// Notes: SDA is open drain; only the enable ever pulls low
`timescale 1ns/10ps
module lgr_i2c (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_oe,
  output lgr_pkg::lgr_wr_s wr,
  output logic [7:0] ptr,
  input wire logic [7:0] rd_data
);
  import lgr_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_REG, ST_DATA, ST_READ, ST_SKIP
  } lgr_st_e;

  lgr_st_e st_q;
  logic scl_m, scl_s, scl_p, sda_m, sda_s, sda_p;
  logic [7:0] sh_q, out_q;
  logic [3:0] cnt_q;
  logic ack_q, nack_q;
  logic rise, fall, start, stop;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      {scl_m, scl_s, scl_p} <= 3'h7;
      {sda_m, sda_s, sda_p} <= 3'h7;
    end else begin
      {scl_m, scl_s, scl_p} <= {scl_i, scl_m, scl_s};
      {sda_m, sda_s, sda_p} <= {sda_i, sda_m, sda_s};
    end
  end

  assign rise = scl_s & ~scl_p;
  assign fall = ~scl_s & scl_p;
  assign start = scl_s & scl_p & sda_p & ~sda_s;
  assign stop = scl_s & scl_p & ~sda_p & sda_s;

  //////////////////////////////////////////////////////////////////////
  // address, register, data order
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= ST_IDLE;
      sh_q <= 8'h00;
      out_q <= 8'h00;
      cnt_q <= 4'h0;
      ack_q <= 1'b0;
      nack_q <= 1'b0;
      sda_oe <= 1'b0;
      ptr <= 8'h00;
      wr <= '0;
    end else begin
      wr.stb <= 1'b0;
      if (start) begin
        st_q <= ST_ADDR;
        cnt_q <= 4'h0;
        ack_q <= 1'b0;
        sda_oe <= 1'b0;
      end else if (stop) begin
        st_q <= ST_IDLE;
        cnt_q <= 4'h0;
        ack_q <= 1'b0;
        sda_oe <= 1'b0;
      end else if (rise) begin
        if (!ack_q && st_q != ST_IDLE && st_q != ST_SKIP) begin
          sh_q <= {sh_q[6:0], sda_s};
          cnt_q <= cnt_q + 4'h1;
        end else if (ack_q && st_q == ST_READ) begin
          nack_q <= sda_s;
        end
      end else if (fall) begin
        if (ack_q) begin
          ack_q <= 1'b0;
          sda_oe <= 1'b0;
          cnt_q <= 4'h0;
          case (st_q)
            ST_ADDR: begin
              if (sh_q[0]) begin
                st_q <= ST_READ;
                out_q <= rd_data;
                sda_oe <= ~rd_data[7];
              end else begin
                st_q <= ST_REG;
              end
            end
            ST_REG: st_q <= ST_DATA;
            ST_READ: begin
              if (nack_q) begin
                st_q <= ST_SKIP;
              end else begin
                out_q <= rd_data;
                sda_oe <= ~rd_data[7];
              end
            end
            default: ;
          endcase
        end else if (cnt_q == 4'h8) begin
          ack_q <= 1'b1;
          sda_oe <= (st_q != ST_READ);
          case (st_q)
            ST_ADDR: begin
              if (sh_q[7:1] != DEV_ADDR) begin
                // A count left at eight would ack a foreign frame later
                cnt_q <= 4'h0;
                st_q <= ST_SKIP;
                ack_q <= 1'b0;
                sda_oe <= 1'b0;
              end
            end
            ST_REG: ptr <= sh_q;
            ST_DATA: wr <= '{stb: 1'b1, addr: ptr, data: sh_q};
            default: ;
          endcase
        end else if (st_q == ST_READ) begin
          out_q <= {out_q[6:0], 1'b0};
          sda_oe <= ~out_q[6];
        end
      end
    end
  end

  ack_drive_a:
  assert property (@(posedge clk) disable iff (!rst_n)
    ack_q && st_q != ST_READ |-> sda_oe)
    else $error("acknowledge not driven low");

  wr_order_a:
  assert property (@(posedge clk) disable iff (!rst_n)
    wr.stb |-> $past(st_q) == ST_DATA && $past(cnt_q) == 4'h8)
    else $error("write strobe outside data byte");

  skip_quiet_a:
  assert property (@(posedge clk) disable iff (!rst_n)
    st_q == ST_SKIP |-> !sda_oe)
    else $error("data line pulled for another target");

endmodule // lgr_i2c

// [core/lgr_ramp.sv]
// Purpose: steps the main group code toward its target
// Assumes: tick is a one-cycle pulse every ramp tick
// Notes: dwell is counted in whole ticks
`timescale 1ns/10ps
module lgr_ramp (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic en,
  input wire logic [4:0] target,
  input wire logic [1:0] step_sel,
  output logic on,
  output logic [4:0] code
);
  import lgr_pkg::*;

  logic [9:0] tcnt_q, len;
  logic moving, step;

  //////////////////////////////////////////////////////////////////////
  // dwell per step select
  always_comb begin
    case (step_sel)
      2'h0: len = STEP0_TK;
      2'h1: len = STEP1_TK;
      2'h2: len = STEP2_TK;
      default: len = STEP3_TK;
    endcase
  end

  assign moving = on && (!en || code != target);
  assign step = moving && tick && tcnt_q == len - 10'h1;

  always_ff @(posedge clk) begin
    if (!rst_n || !moving || step) begin
      tcnt_q <= 10'h0;
    end else if (tick) begin
      tcnt_q <= tcnt_q + 10'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      on <= 1'b0;
      code <= 5'h00;
    end else if (en && !on) begin
      on <= 1'b1;
      code <= 5'h00;
    end else if (step) begin
      if (!en && code == 5'h00) begin
        on <= 1'b0;
      end else if (!en || code > target) begin
        code <= code - 5'h01;
      end else begin
        code <= code + 5'h01;
      end
    end
  end

  single_step_a:
  assert property (@(posedge clk) disable iff (!rst_n)
    on && $past(on) && code != $past(code) |->
    code == $past(code) + 5'h01 || code == $past(code) - 5'h01)
    else $error("ramp jumped more than one code");

  dwell_len_a:
  assert property (@(posedge clk) disable iff (!rst_n)
    $past(on) && code != $past(code) |->
    $past(tcnt_q) == $past(len) - 10'h1)
    else $error("ramp stepped before dwell ended");

endmodule // lgr_ramp

// [core/lgr_top.sv]
// Purpose: control registers and sink drive of an eight-sink LED driver
// Assumes: two-wire bus pins arrive asynchronously; NRST is synchronous
// Notes: sinks 0-3 main, 4-5 movable, 6 aux, 7 indicator
// Function
// - main sinks only while main enabled or ramping down
// - aux sinks only while aux enabled
// - indicator sink only while its enable set
// - shutdown bit forces movable sink off
// - movable sink follows main or aux
// - main code five bits, fixed ones above
// - aux code three bits, all ones full
// - indicator code with fixed upper ones
// - main has 32 rising exponential levels
// - aux, indicator eight levels ten to hundred
// - step field sets dwell per code
// - only main group ramps
// - ramp one code at a time
// - ramp time is codes times dwell
// - delay field selects gain transition delay
// - indicator group is always one sink
// - movable sinks start in aux group
// - write is address, register, data
// - acknowledge every byte sent to own address
// - reset shuts outputs, restores registers
`timescale 1ns/10ps
module lgr_top #(
  parameter int TICK_CYCLES = lgr_pkg::RAMP_TICK_CYC,
  parameter int VF0_CYCLES = lgr_pkg::VF0_CYC,
  parameter int VF1_CYCLES = lgr_pkg::VF1_CYC,
  parameter int VF2_CYCLES = lgr_pkg::VF2_CYC,
  parameter int VF3_CYCLES = lgr_pkg::VF3_CYC
) (
  input wire logic CLOCK,
  input wire logic NRST,
  input wire logic SCL_I,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE,
  output lgr_pkg::lgr_sink_s [7:0] SINKS,
  output logic [16:0] GAIN_DELAY_CYCLES
);
  import lgr_pkg::*;

  lgr_gp_s gp_q;
  logic [MAIN_W-1:0] main_code_q;
  logic [BC_W-1:0] aux_code_q, ind_code_q;
  logic [1:0] ramp_step_select, gain_delay_select;
  lgr_wr_s wr;
  logic [7:0] ptr, rd_data;
  logic [31:0] div_q;
  logic tick, ramp_on;
  logic [4:0] ramp_code;
  logic [16:0] main_lvl, aux_lvl, ind_lvl;
  lgr_sink_s sink_d [8];

  //////////////////////////////////////////////////////////////////////
  // Bus target

  // Open drain: the level driven is always low
  assign SDA_O = 1'b0;

  lgr_i2c u_i2c (
    .clk(CLOCK),
    .rst_n(NRST),
    .scl_i(SCL_I),
    .sda_i(SDA_I),
    .sda_oe(SDA_OE),
    .wr(wr),
    .ptr(ptr),
    .rd_data(rd_data)
  );

  //////////////////////////////////////////////////////////////////////
  // Registers; only variable fields are stored

  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      gp_q <= GP_RST[GP_W-1:0];
    end else if (wr.stb && wr.addr == OFS_GP) begin
      gp_q <= wr.data[GP_W-1:0];
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      main_code_q <= MAIN_RST[MAIN_W-1:0];
    end else if (wr.stb && wr.addr == OFS_MAIN) begin
      main_code_q <= wr.data[MAIN_W-1:0];
    end
  end

  // indicator code held three bits wide
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      aux_code_q <= AUX_RST[BC_W-1:0];
      ind_code_q <= IND_RST[BC_W-1:0];
    end else if (wr.stb && wr.addr == OFS_AUX) begin
      aux_code_q <= wr.data[BC_W-1:0];
    end else if (wr.stb && wr.addr == OFS_IND) begin
      ind_code_q <= wr.data[BC_W-1:0];
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      ramp_step_select <= RAMP_RST[1:0];
      gain_delay_select <= VF_RST[1:0];
    end else if (wr.stb && wr.addr == OFS_RAMP) begin
      ramp_step_select <= wr.data[1:0];
    end else if (wr.stb && wr.addr == OFS_VF) begin
      gain_delay_select <= wr.data[1:0];
    end
  end

  always_comb begin
    case (ptr)
      OFS_GP: rd_data = GP_FIXED | {1'b0, gp_q};
      OFS_RAMP: rd_data = RAMP_FIXED | {6'h00, ramp_step_select};
      OFS_VF: rd_data = VF_FIXED | {6'h00, gain_delay_select};
      OFS_MAIN: rd_data = MAIN_FIXED | {3'h0, main_code_q};
      OFS_AUX: rd_data = AUX_FIXED | {5'h00, aux_code_q};
      OFS_IND: rd_data = IND_FIXED | {5'h00, ind_code_q};
      default: rd_data = 8'h00;
    endcase
  end

  //////////////////////////////////////////////////////////////////////
  // Ramp of the main group

  // Free-running tick; first dwell may be short by up to one tick
  assign tick = div_q == 32'(TICK_CYCLES - 1);

  always_ff @(posedge CLOCK) begin
    if (!NRST || tick) begin
      div_q <= 32'h0;
    end else begin
      div_q <= div_q + 32'h1;
    end
  end

  lgr_ramp u_ramp (
    .clk(CLOCK),
    .rst_n(NRST),
    .tick(tick),
    .en(gp_q.main_en),
    .target(main_code_q),
    .step_sel(ramp_step_select),
    .on(ramp_on),
    .code(ramp_code)
  );

  //////////////////////////////////////////////////////////////////////
  // Sink drive

  assign main_lvl = MAIN_TBL[ramp_code];
  assign aux_lvl = BC_TBL[aux_code_q];
  assign ind_lvl = BC_TBL[ind_code_q];

  for (genvar i = 0; i < 8; i++) begin : g_sink
    if (i < 4) begin : g_main
      assign sink_d[i] = '{on: ramp_on, level: main_lvl};
    end else if (i < 6) begin : g_move
      logic to_main, off;
      assign to_main = (i == 4) ? gp_q.first_to_main : gp_q.second_to_main;
      assign off = (i == 4) ? gp_q.first_off : gp_q.second_off;
      assign sink_d[i] = '{on: !off && (to_main ? ramp_on : gp_q.aux_en),
        level: to_main ? main_lvl : aux_lvl};
    end else if (i == 6) begin : g_aux
      assign sink_d[i] = '{on: gp_q.aux_en, level: aux_lvl};
    end else begin : g_ind
      assign sink_d[i] = '{on: gp_q.ind_en, level: ind_lvl};
    end
  end

  always_ff @(posedge CLOCK) begin
    for (int k = 0; k < 8; k++) begin
      if (!NRST) begin
        SINKS[k] <= '0;
      end else begin
        SINKS[k] <= sink_d[k];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Gain transition delay

  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      GAIN_DELAY_CYCLES <= 17'(VF0_CYCLES);
    end else begin
      case (gain_delay_select)
        2'h0: GAIN_DELAY_CYCLES <= 17'(VF0_CYCLES);
        2'h1: GAIN_DELAY_CYCLES <= 17'(VF1_CYCLES);
        2'h2: GAIN_DELAY_CYCLES <= 17'(VF2_CYCLES);
        default: GAIN_DELAY_CYCLES <= 17'(VF3_CYCLES);
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Checks

  main_off_a:
  assert property (@(posedge CLOCK) disable iff (!NRST)
    !gp_q.main_en && !ramp_on |=> !SINKS[0].on && !SINKS[3].on)
    else $error("main sink on while group disabled");

  aux_off_a:
  assert property (@(posedge CLOCK) disable iff (!NRST)
    !gp_q.aux_en |=> !SINKS[6].on)
    else $error("aux sink on while group disabled");

  ind_off_a:
  assert property (@(posedge CLOCK) disable iff (!NRST)
    !gp_q.ind_en |=> !SINKS[7].on)
    else $error("indicator sink on while disabled");

  shut_off_a:
  assert property (@(posedge CLOCK) disable iff (!NRST)
    gp_q.first_off || gp_q.second_off |=>
    !(SINKS[4].on && $past(gp_q.first_off)) &&
    !(SINKS[5].on && $past(gp_q.second_off)))
    else $error("shut down sink still driven");

  move_route_a:
  assert property (@(posedge CLOCK) disable iff (!NRST)
    !gp_q.first_off && gp_q.first_to_main |=>
    SINKS[4].on == SINKS[0].on && SINKS[4].level == SINKS[0].level)
    else $error("movable sink not following main group");

  aux_full_a:
  assert property (@(posedge CLOCK) disable iff (!NRST)
    gp_q.aux_en && aux_code_q == 3'h7 |=> SINKS[6].level == 17'd100000)
    else $error("aux full scale level wrong");

  fixed_bits_a:
  assert property (@(posedge CLOCK) disable iff (!NRST)
    ptr == OFS_MAIN |-> rd_data[7:5] == 3'h7)
    else $error("fixed bits of main code read wrong");

  reset_off_a:
  assert property (@(posedge CLOCK)
    !NRST |=> SINKS == '0 && gp_q == '0)
    else $error("reset did not clear outputs");

  second_route_a:
  assert property (@(posedge CLOCK) disable iff (!NRST)
    !gp_q.second_off && !gp_q.second_to_main |=>
    SINKS[5].on == SINKS[6].on && SINKS[5].level == SINKS[6].level)
    else $error("movable sink not following aux group");

  main_code_a:
  assert property (@(posedge CLOCK) disable iff (!NRST)
    wr.stb && wr.addr == OFS_MAIN |=>
    main_code_q == $past(wr.data[MAIN_W-1:0]))
    else $error("main code not taken from write");

  aux_code_a:
  assert property (@(posedge CLOCK) disable iff (!NRST)
    wr.stb && wr.addr == OFS_AUX |=> aux_code_q == $past(wr.data[2:0]))
    else $error("aux code not taken from write");

  ind_code_a:
  assert property (@(posedge CLOCK) disable iff (!NRST)
    wr.stb && wr.addr == OFS_IND |=> ind_code_q == $past(wr.data[2:0]))
    else $error("indicator code not taken from write");

  main_full_a:
  assert property (@(posedge CLOCK) disable iff (!NRST)
    ramp_on && ramp_code == 5'h1F |=> SINKS[1].level == 17'd100000)
    else $error("main full scale level wrong");

  aux_direct_a:
  assert property (@(posedge CLOCK) disable iff (!NRST)
    gp_q.aux_en |=> SINKS[6].level == BC_TBL[$past(aux_code_q)])
    else $error("aux level not applied at once");

  gain_fast_a:
  assert property (@(posedge CLOCK) disable iff (!NRST)
    gain_delay_select == 2'h3 |=> GAIN_DELAY_CYCLES == 17'(VF3_CYCLES))
    else $error("shortest gain delay not selected");

  ind_alone_a:
  assert property (@(posedge CLOCK) disable iff (!NRST)
    !gp_q.aux_en && !ramp_on |=> !SINKS[4].on && !SINKS[5].on)
    else $error("movable sink lit with its groups off");

  main_gate_a:
  assert property (@(posedge CLOCK) disable iff (!NRST)
    !ramp_on |=> !SINKS[1].on && !SINKS[2].on)
    else $error("middle main sinks lit while ramp off");

  reset_regs_a:
  assert property (@(posedge CLOCK)
    !NRST |=> main_code_q == MAIN_RST[MAIN_W-1:0] &&
    aux_code_q == AUX_RST[BC_W-1:0] && ind_code_q == IND_RST[BC_W-1:0])
    else $error("reset did not restore brightness codes");

endmodule // lgr_top

// [tb/lgr_i2c_master.sv]
// Purpose: two-wire bus master standing in for the host controller
// Assumes: pull-ups on both lines; SCL is driven only by this model
// Notes: each bus phase lasts Q clocks, above the 4-clock minimum
`timescale 1ns/10ps
module lgr_i2c_master #(
  parameter int Q = 5
) (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  import lgr_pkg::*;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic gap();
    repeat (Q) @(posedge clk);
  endtask
  task automatic start();
    sda_low <= 1'b0;
    gap();
    scl <= 1'b1;
    gap();
    sda_low <= 1'b1;
    gap();
    scl <= 1'b0;
    gap();
  endtask
  task automatic stop();
    sda_low <= 1'b1;
    gap();
    scl <= 1'b1;
    gap();
    sda_low <= 1'b0;
    gap();
  endtask
  task automatic put_bit(input logic b, output logic s);
    sda_low <= ~b;
    gap();
    scl <= 1'b1;
    gap();
    s = sda;
    gap();
    scl <= 1'b0;
    gap();
  endtask
  // most significant bit first, then ack
  task automatic put_byte(input logic [7:0] v, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      put_bit(v[i], s);
    end
    put_bit(1'b1, s);
    ack = ~s;
  endtask
  // Master ends every read byte with a NACK
  task automatic get_byte(output logic [7:0] v);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      put_bit(1'b1, s);
      v[i] = s;
    end
    put_bit(1'b1, s);
  endtask
  task automatic write(input logic [6:0] dev, input logic [7:0] r,
    input logic [7:0] d, output logic [2:0] acks);
    start();
    put_byte({dev, 1'b0}, acks[2]);
    put_byte(r, acks[1]);
    put_byte(d, acks[0]);
    stop();
  endtask
  task automatic read(input logic [7:0] r, output logic [7:0] d);
    logic a;
    start();
    put_byte({DEV_ADDR, 1'b0}, a);
    put_byte(r, a);
    start();
    put_byte({DEV_ADDR, 1'b1}, a);
    get_byte(d);
    stop();
  endtask
endmodule // lgr_i2c_master

// [tb/testbench.sv]
// Purpose: self-checking bench of the LED group control block
// Assumes: short tick and delay parameters keep the run brief
// Notes: levels are expected from the package tables and fixed steps
`timescale 1ns/10ps
module testbench;
  import lgr_pkg::*;
  localparam int TK = 4;
  localparam logic [3:0][16:0] VFC = {17'h2, 17'h4, 17'h6, 17'h8};
  localparam logic [5:0][7:0] REGS = {OFS_IND, OFS_AUX, OFS_MAIN,
    OFS_VF, OFS_RAMP, OFS_GP};
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic scl;
  logic sda_low;
  logic sda_oe;
  logic sda;
  logic sda_o;
  lgr_sink_s [7:0] sinks;
  logic [16:0] gdc;
  logic [2:0] acks;
  logic [7:0] rd;
  int err_count = 0;
  int n_checks = 0;
  int seed_v;
  always #12.5 clk = ~clk;
  // Wired data line with pull-up
  assign sda = !sda_low && (sda_oe ? sda_o : 1'b1);
  lgr_top #(
    .TICK_CYCLES(TK),
    .VF0_CYCLES(VFC[0]),
    .VF1_CYCLES(VFC[1]),
    .VF2_CYCLES(VFC[2]),
    .VF3_CYCLES(VFC[3])
  ) uut (
    .CLOCK(clk),
    .NRST(nrst),
    .SCL_I(scl),
    .SDA_I(sda),
    .SDA_O(sda_o),
    .SDA_OE(sda_oe),
    .SINKS(sinks),
    .GAIN_DELAY_CYCLES(gdc)
  );
  lgr_i2c_master m (
    .clk(clk),
    .sda(sda),
    .scl(scl),
    .sda_low(sda_low)
  );
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: %0h, wanted %0h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d, errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  function automatic logic [16:0] lvl_bc(input int c);
    return (c == 7) ? 17'h186A0 : 17'(17'h2710 * (c + 1));
  endfunction
  function automatic logic [7:0] reg_at(input int i);
    return (i < 6) ? REGS[i] : 8'h30;
  endfunction
  // Read-back: fixed bits from the layout, the rest as written
  function automatic logic [7:0] rb(input logic [7:0] a,
    input logic [7:0] d);
    case (a)
      OFS_GP: return d & 8'h7F;
      OFS_RAMP: return 8'hF0 | (d & 8'h03);
      OFS_VF: return 8'hFC | (d & 8'h03);
      OFS_MAIN: return 8'hE0 | (d & 8'h1F);
      OFS_AUX, OFS_IND: return 8'hF8 | (d & 8'h07);
      default: return 8'h00;
    endcase
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    m.write(DEV_ADDR, a, d, acks);
    check(acks, 3'h7);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    m.read(a, rd);
    check(rd, e);
  endtask
  task automatic reset_check();
    nrst <= 1'b0;
    repeat (10) @(posedge clk);
    @(negedge clk);
    check(sinks === '0, 1'b1);
    check(sda_oe, 1'b0);
    check(gdc, VFC[0]);
    @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    for (int i = 0; i < 7; i++) begin
      rd_chk(reg_at(i), rb(reg_at(i), 8'h00));
    end
  endtask
  // Each level change of a lit main sink must be one code step
  task automatic follow(input int k, input int t, output int n);
    n = 0;
    while (k != t && n < 20000) begin
      @(negedge clk);
      if (sinks[0].on) begin
        n++;
        if (sinks[0].level !== MAIN_TBL[k]) begin
          k += (t > k) ? 1 : -1;
          check(sinks[0].level, MAIN_TBL[k]);
        end
      end
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    int n;
    int t;
    int d;
    int mc;
    int ca;
    logic [7:0] g;
    logic on_e;
    seed_v = $urandom(56);
    reset_check();
    // Foreign target address gets no ack and changes nothing
    m.write(7'h37, OFS_GP, 8'h01, acks);
    check(acks, 3'h0);
    rd_chk(OFS_GP, 8'h00);
    for (int i = 0; i < 7; i++) begin
      g = (i < 3) ? 8'hFF : 8'($urandom);
      wr(reg_at(i), g);
      rd_chk(reg_at(i), rb(reg_at(i), g));
    end
    reset_check();
    // Up and down ramps at every step time
    for (int s = 0; s < 4; s++) begin
      t = (s == 0) ? 31 : (s == 3) ? 1 : 2;
      d = (s == 0) ? 1 : 250 << (s - 1);
      wr(OFS_RAMP, 8'(s));
      wr(OFS_MAIN, 8'(t));
      fork
        wr(OFS_GP, 8'h01);
        follow(0, t, n);
      join
      check(n >= t*d*TK - TK - 2 && n <= t*d*TK + 3, 1'b1);
      check(sinks[3], {1'b1, MAIN_TBL[t]});
      check(sinks[4].on, 1'b0);
      fork
        wr(OFS_GP, 8'h00);
        follow(t, 0, n);
      join
      for (n = 0; n < 2*d*TK + 8 && sinks[0].on; n++) begin
        @(negedge clk);
      end
      check(sinks[0].on, 1'b0);
    end
    // Aux and indicator change at once with the slowest step set
    wr(OFS_GP, 8'h06);
    for (int c = 0; c < 8; c++) begin
      wr(OFS_AUX, 8'(c));
      wr(OFS_IND, 8'(7 - c));
      check(sinks[6], {1'b1, lvl_bc(c)});
      check(sinks[4], {1'b1, lvl_bc(c)});
      check(sinks[7], {1'b1, lvl_bc(7 - c)});
      check(sinks[0].on, 1'b0);
    end
    ca = $urandom_range(7);
    mc = $urandom_range(31);
    wr(OFS_RAMP, 8'h00);
    wr(OFS_AUX, 8'(ca));
    wr(OFS_MAIN, 8'(mc));
    wr(OFS_GP, 8'h01);
    repeat (32 * TK + 8) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      g = (i == 0) ? 8'h7F : (i == 1) ? 8'h1F : 8'($urandom) | 8'h01;
      wr(OFS_GP, g);
      for (int s = 0; s < 2; s++) begin
        on_e = !g[5 + s] && (g[3 + s] || g[1]);
        check(sinks[4 + s].on, on_e);
        if (on_e) begin
          check(sinks[4 + s].level,
            g[3 + s] ? MAIN_TBL[mc] : lvl_bc(ca));
        end
      end
      check(sinks[6].on, g[1]);
      check(sinks[7].on, g[2]);
    end
    for (int s = 3; s >= 0; s--) begin
      wr(OFS_VF, 8'(s) | 8'hFC);
      check(gdc, VFC[s]);
    end
    reset_check();
    complete_run();
  end
  // Hang guard: a clean run takes about 83k cycles
  initial begin
    repeat (96000) @(posedge clk);
    err_count++;
    complete_run();
  end
endmodule // testbench
